// file: core/servo_cmd_pkg.sv
// Shared constants and types for the servo command executor
package servo_cmd_pkg;
	// Command codes as they arrive in the first word of a command
	localparam logic [15:0] CODE_PATCH = 16'h008b;
	localparam logic [15:0] CODE_STORE = 16'h009a;
	localparam logic [15:0] CODE_CLEAR = 16'h00a3;
	localparam logic [15:0] CODE_COPY = 16'h0092;
	// Data register file geometry
	localparam int REG_AW = 8;
	localparam int REG_DW = 32;
	// Which status bits latch; the rest follow their condition
	localparam logic [15:0] PRI_LATCH_MASK = 16'hff00;
	localparam logic [15:0] SEC_LATCH_MASK = 16'h00ff;
	// Values after reset
	localparam logic [15:0] PRI_STATUS_RESET = 16'h0000;
	localparam logic [15:0] SEC_STATUS_RESET = 16'h0000;
	localparam logic [31:0] TARGET_RESET = 32'h0000_0000;
	// Word collector states
	typedef enum logic [1:0] {
		ST_CODE,
		ST_ARG1,
		ST_ARG2,
		ST_ARG3
	} cmd_state_t;
endpackage : servo_cmd_pkg

// file: core/data_reg_mem.sv
// Data register file: one write port, one registered read port
`timescale 1ns/100ps
module data_reg_mem (
	input wire logic mclk,
	input wire logic we,
	input wire logic [servo_cmd_pkg::REG_AW-1:0] waddr,
	input wire logic [servo_cmd_pkg::REG_DW-1:0] wdata,
	input wire logic re,
	input wire logic [servo_cmd_pkg::REG_AW-1:0] raddr,
	output logic [servo_cmd_pkg::REG_DW-1:0] rdata
);
	// Storage, no reset so it maps onto RAM
	logic [servo_cmd_pkg::REG_DW-1:0] mem [2**servo_cmd_pkg::REG_AW];

	// Write port
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data comes out of a register, one cycle after re
	always_ff @(posedge mclk) begin
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule : data_reg_mem

// file: core/servo_program_command_exec.sv
// Executor for program patch, register store, status clear and target copy
`timescale 1ns/100ps
module servo_program_command_exec (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire logic [15:0] cmd_word,
	input wire logic cmd_from_serial,
	input wire logic cmd_thread2,
	input wire logic exec_busy,
	input wire logic [31:0] position,
	input wire logic motion_target_valid,
	input wire logic [31:0] motion_target,
	input wire logic [15:0] pri_cond,
	input wire logic [15:0] sec_cond,
	output logic ack,
	output logic nak,
	output logic pb_we,
	output logic [15:0] pb_addr,
	output logic [15:0] pb_data,
	output logic [31:0] target,
	output logic windup_clear,
	output logic [15:0] primary_internal_status_word,
	output logic [15:0] secondary_internal_status_word
);
	// Reset release synchroniser
	logic rst_meta_q;
	logic rst_n_q;
	// Collector state and captured fields
	servo_cmd_pkg::cmd_state_t st_q, st_d;
	logic [15:0] code_q; // Command code of the frame in flight
	logic [servo_cmd_pkg::REG_AW-1:0] reg_q; // Selected data register
	logic [15:0] hi_q; // Upper half of store data
	logic reject_q; // Store frame will be refused
	// Decoded one-cycle actions
	logic ok_d, bad_d, clr_d, copy_d, mem_we, mem_re, pb_fire;
	logic [servo_cmd_pkg::REG_DW-1:0] rd_data;
	// Output registers
	logic ack_q, nak_q, pb_we_q, windup_q;
	logic [15:0] pb_addr_q, pb_data_q, pri_stat_q, sec_stat_q;
	logic [31:0] target_q;

	// Release reset through two flops; assertion is immediate
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Word decoding: what each arriving word does
	always_comb begin
		st_d = st_q;
		ok_d = 1'b0;
		bad_d = 1'b0;
		clr_d = 1'b0;
		copy_d = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		pb_fire = 1'b0;
		if (cmd_valid) begin
			unique case (st_q)
				servo_cmd_pkg::ST_CODE: begin
					if (cmd_word == servo_cmd_pkg::CODE_PATCH) begin
						st_d = servo_cmd_pkg::ST_ARG1;
					end else if (cmd_word == servo_cmd_pkg::CODE_STORE) begin
						st_d = servo_cmd_pkg::ST_ARG1;
					end else if (cmd_word == servo_cmd_pkg::CODE_CLEAR) begin
						clr_d = 1'b1;
						ok_d = 1'b1;
					end else if (cmd_word == servo_cmd_pkg::CODE_COPY) begin
						// Secondary thread may not move the target
						copy_d = !cmd_thread2;
						ok_d = !cmd_thread2;
						bad_d = cmd_thread2;
					end else begin
						// Codes outside this block are refused
						bad_d = 1'b1;
					end
				end
				servo_cmd_pkg::ST_ARG1: begin
					// Fetch register early so patch data is ready next word
					mem_re = (code_q == servo_cmd_pkg::CODE_PATCH);
					st_d = servo_cmd_pkg::ST_ARG2;
				end
				servo_cmd_pkg::ST_ARG2: begin
					if (code_q == servo_cmd_pkg::CODE_PATCH) begin
						pb_fire = 1'b1;
						ok_d = 1'b1;
						st_d = servo_cmd_pkg::ST_CODE;
					end else begin
						st_d = servo_cmd_pkg::ST_ARG3;
					end
				end
				servo_cmd_pkg::ST_ARG3: begin
					// Rejected store still swallows its words to keep framing
					mem_we = !reject_q;
					ok_d = !reject_q;
					bad_d = reject_q;
					st_d = servo_cmd_pkg::ST_CODE;
				end
			endcase
		end
	end

	// Collector state and captured operands
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= servo_cmd_pkg::ST_CODE;
			code_q <= 16'h0000;
			reg_q <= '0;
			hi_q <= 16'h0000;
			reject_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (cmd_valid && st_q == servo_cmd_pkg::ST_CODE) begin
				code_q <= cmd_word;
				// Serial store during execution is meant for programs only
				reject_q <= cmd_from_serial && exec_busy;
			end
			if (cmd_valid && st_q == servo_cmd_pkg::ST_ARG1) begin
				reg_q <= cmd_word[servo_cmd_pkg::REG_AW-1:0];
			end
			if (cmd_valid && st_q == servo_cmd_pkg::ST_ARG2) begin
				hi_q <= cmd_word;
			end
		end
	end

	// Register file; store writes hi then lo halves as one word
	data_reg_mem data_reg_mem_i (
		.mclk(mclk),
		.we(mem_we),
		.waddr(reg_q),
		.wdata({hi_q, cmd_word}),
		.re(mem_re),
		.raddr(cmd_word[servo_cmd_pkg::REG_AW-1:0]),
		.rdata(rd_data)
	);

	// Program buffer patch, low half only, value passed unchecked
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pb_we_q <= 1'b0;
			pb_addr_q <= 16'h0000;
			pb_data_q <= 16'h0000;
		end else begin
			pb_we_q <= pb_fire;
			if (pb_fire) begin
				pb_addr_q <= cmd_word;
				pb_data_q <= rd_data[15:0];
			end
		end
	end

	// Answers: acknowledge carries no payload
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_q <= 1'b0;
			nak_q <= 1'b0;
		end else begin
			ack_q <= ok_d;
			nak_q <= bad_d;
		end
	end

	// Status words; a new condition wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pri_stat_q <= servo_cmd_pkg::PRI_STATUS_RESET;
			sec_stat_q <= servo_cmd_pkg::SEC_STATUS_RESET;
		end else begin
			pri_stat_q <= pri_cond
				| (pri_stat_q & servo_cmd_pkg::PRI_LATCH_MASK & {16{!clr_d}});
			sec_stat_q <= sec_cond
				| (sec_stat_q & servo_cmd_pkg::SEC_LATCH_MASK & {16{!clr_d}});
		end
	end

	// Target: command copy beats motion sources in the same cycle
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			target_q <= servo_cmd_pkg::TARGET_RESET;
			windup_q <= 1'b0;
		end else begin
			windup_q <= copy_d;
			if (copy_d) begin
				target_q <= position;
			end else if (motion_target_valid) begin
				target_q <= motion_target;
			end
		end
	end

	assign ack = ack_q;
	assign nak = nak_q;
	assign pb_we = pb_we_q;
	assign pb_addr = pb_addr_q;
	assign pb_data = pb_data_q;
	assign target = target_q;
	assign windup_clear = windup_q;
	assign primary_internal_status_word = pri_stat_q;
	assign secondary_internal_status_word = sec_stat_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_q);

	// Command frames seen from the word stream; only back to back words are watched
	sequence patch_frame_s;
		cmd_valid && st_q == servo_cmd_pkg::ST_CODE && cmd_word == servo_cmd_pkg::CODE_PATCH
		##1 cmd_valid;
	endsequence
	// Serial store during execution followed by its three parameter words
	sequence refused_store_s;
		cmd_valid && st_q == servo_cmd_pkg::ST_CODE && cmd_word == servo_cmd_pkg::CODE_STORE
		&& cmd_from_serial && exec_busy ##1 cmd_valid [*3];
	endsequence
	sequence clear_word_s;
		cmd_valid && st_q == servo_cmd_pkg::ST_CODE && cmd_word == servo_cmd_pkg::CODE_CLEAR;
	endsequence
	sequence copy_word_s;
		cmd_valid && st_q == servo_cmd_pkg::ST_CODE && cmd_word == servo_cmd_pkg::CODE_COPY;
	endsequence

	chk_patch_reads: assert property (patch_frame_s |=> mem_re == 1'b0 && $past(mem_re))
		else $error("patch did not fetch register on its second word");
	chk_patch_write: assert property (pb_fire |=> pb_we && ack && pb_data == $past(rd_data[15:0]))
		else $error("patch wrote wrong data or missed ack");
	chk_store_reject: assert property (refused_store_s |-> !mem_we ##1 nak)
		else $error("store written while it should be rejected");
	chk_store_answer: assert property (cmd_valid && st_q == servo_cmd_pkg::ST_ARG3
		|=> ack != $past(reject_q) && nak == $past(reject_q))
		else $error("store answer does not match rejection");
	chk_clear_primary: assert property (clear_word_s |=> ack ##0 pri_stat_q == $past(pri_cond))
		else $error("primary latched status not cleared");
	chk_clear_second: assert property (clear_word_s |=> sec_stat_q == $past(sec_cond))
		else $error("secondary latched status not cleared");
	chk_latch_hold: assert property (!clr_d |=> ($past(pri_stat_q) & servo_cmd_pkg::PRI_LATCH_MASK
		& ~pri_stat_q) == 16'h0000)
		else $error("latched status bit dropped without a clear");
	chk_copy_load: assert property (copy_word_s ##0 !cmd_thread2
		|=> target_q == $past(position) && windup_clear && ack)
		else $error("target copy did not load position");
	chk_copy_thread: assert property (copy_word_s ##0 cmd_thread2 |=> nak && !windup_clear)
		else $error("target copy accepted from secondary thread");
	chk_answer_excl: assert property (!(ack && nak))
		else $error("ack and nak together");
endmodule : servo_program_command_exec

// file: sim/cmd_host_model.sv
// Host model that issues coded command frames word by word
`timescale 1ns/100ps
module cmd_host_model (
	input wire logic mclk,
	output logic cmd_valid,
	output logic [15:0] cmd_word,
	output logic cmd_from_serial,
	output logic cmd_thread2,
	output logic exec_busy
);
	// Idle at time zero; word line starts at a neutral pattern
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h5a5a;
		cmd_from_serial = 1'b0;
		cmd_thread2 = 1'b0;
		exec_busy = 1'b0;
	end
	// Sends n words back to back, returns settled in the answer cycle
	task automatic send(input logic [15:0] w [4], input int n, input logic [2:0] ctx);
		for (int k = 0; k < n; k++) begin
			@(posedge mclk);
			cmd_valid <= 1'b1;
			cmd_word <= w[k];
			{cmd_from_serial, cmd_thread2, exec_busy} <= ctx;
		end
		@(posedge mclk);
		cmd_valid <= 1'b0;
		// Stale word is inverted so nothing can lean on it
		cmd_word <= ~w[n-1];
		#1;
	endtask : send
endmodule : cmd_host_model

// file: sim/servo_program_command_exec_bench.sv
// Self-checking bench for the servo command executor
`timescale 1ns/100ps
module servo_program_command_exec_bench;
	logic mclk = 1'b0; // 100 MHz clock
	logic rstn = 1'b0; // Active low reset
	logic cmd_valid, cmd_from_serial, cmd_thread2, exec_busy;
	logic [15:0] cmd_word;
	logic [31:0] position = 32'h5555_aaaa; // Present position
	logic motion_target_valid = 1'b0; // Motion source load strobe
	logic [31:0] motion_target = 32'h0000_0011;
	logic [15:0] pri_cond = 16'h0000; // Raw primary conditions
	logic [15:0] sec_cond = 16'h0000; // Raw secondary conditions
	logic ack, nak, pb_we, windup_clear;
	logic [15:0] pb_addr, pb_data, pri_stat, sec_stat;
	logic [31:0] target;
	int failures = 0;
	int checked = 0;
	// Clock generator
	always #5 mclk = ~mclk;
	cmd_host_model cmd_host_model_i (.mclk(mclk), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .cmd_from_serial(cmd_from_serial),
		.cmd_thread2(cmd_thread2), .exec_busy(exec_busy));
	servo_program_command_exec servo_program_command_exec_i (.mclk(mclk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_from_serial(cmd_from_serial),
		.cmd_thread2(cmd_thread2), .exec_busy(exec_busy), .position(position),
		.motion_target_valid(motion_target_valid), .motion_target(motion_target),
		.pri_cond(pri_cond), .sec_cond(sec_cond), .ack(ack), .nak(nak), .pb_we(pb_we),
		.pb_addr(pb_addr), .pb_data(pb_data), .target(target), .windup_clear(windup_clear),
		.primary_internal_status_word(pri_stat), .secondary_internal_status_word(sec_stat));
	// Compare one observed value against its expectation
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Verdict and end of run
	task automatic tally_and_finish;
		$display("Mismatches %0d of %0d comparisons", failures, checked);
		if (failures == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	// Answer cycle must carry exactly one of ack or nak
	task automatic chk_answer(input logic a);
		chk("ack", a, ack);
		chk("nak", !a, nak);
	endtask : chk_answer
	// Store a full word, then patch its low half to a negative location
	task automatic run_store_patch;
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_STORE, 16'h0005, 16'hdead, 16'hbeef}, 4, 3'b000);
		chk_answer(1'b1);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_PATCH, 16'h0005, 16'h8000, 16'h0000}, 3, 3'b010);
		chk_answer(1'b1);
		chk("pb_we", 1, pb_we);
		chk("pb_addr", 16'h8000, pb_addr);
		chk("pb_data", 16'hbeef, pb_data);
	endtask : run_store_patch
	// Serial store while busy is refused and leaves the register alone
	task automatic run_refused_store;
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_STORE, 16'h0005, 16'h1234, 16'h5678}, 4, 3'b101);
		chk_answer(1'b0);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_STORE, 16'h0006, 16'hffff, 16'h0001}, 4, 3'b010);
		chk_answer(1'b1);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_PATCH, 16'h0005, 16'h0042, 16'h0000}, 3, 3'b000);
		chk("pb_data", 16'hbeef, pb_data);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_PATCH, 16'h0006, 16'h0043, 16'h0000}, 3, 3'b000);
		chk("pb_data", 16'h0001, pb_data);
	endtask : run_refused_store
	// Pulse every condition, see latches hold, then clear them
	task automatic run_status_clear;
		@(posedge mclk);
		pri_cond <= 16'hffff;
		sec_cond <= 16'hffff;
		@(posedge mclk);
		pri_cond <= 16'h0000;
		sec_cond <= 16'h0000;
		repeat (2) @(posedge mclk);
		#1;
		chk("pri_stat", servo_cmd_pkg::PRI_LATCH_MASK, pri_stat);
		chk("sec_stat", servo_cmd_pkg::SEC_LATCH_MASK, sec_stat);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_CLEAR, 16'h0, 16'h0, 16'h0}, 1, 3'b010);
		chk_answer(1'b1);
		chk("pri_stat", 16'h0000, pri_stat);
		chk("sec_stat", 16'h0000, sec_stat);
	endtask : run_status_clear
	// Motion load, target copy, a refused copy and an unknown code
	task automatic run_target_copy;
		@(posedge mclk);
		motion_target_valid <= 1'b1;
		@(posedge mclk);
		motion_target_valid <= 1'b0;
		@(posedge mclk);
		#1;
		chk("target", 32'h0000_0011, target);
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_COPY, 16'h0, 16'h0, 16'h0}, 1, 3'b000);
		chk_answer(1'b1);
		chk("windup_clear", 1, windup_clear);
		chk("target", 32'h5555_aaaa, target);
		// New position on a clock edge so a refused copy would show it
		@(posedge mclk);
		position <= 32'h0000_0777;
		cmd_host_model_i.send('{servo_cmd_pkg::CODE_COPY, 16'h0, 16'h0, 16'h0}, 1, 3'b010);
		chk_answer(1'b0);
		chk("windup_clear", 0, windup_clear);
		chk("target", 32'h5555_aaaa, target);
		cmd_host_model_i.send('{16'h00ff, 16'h0, 16'h0, 16'h0}, 1, 3'b000);
		chk_answer(1'b0);
	endtask : run_target_copy
	// Watchdog cuts a hang short
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		run_store_patch();
		run_refused_store();
		run_status_clear();
		run_target_copy();
		tally_and_finish();
	end
endmodule : servo_program_command_exec_bench
